// ---- hdl/mrc_module_reset_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrc_module_reset_control
  import mrc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = mrc_pkg::HW_HOLD_CYC,
  parameter int unsigned REGUP_CYC = mrc_pkg::REG_UP_CYC,
  parameter int unsigned BBHOLD_CYC = mrc_pkg::BB_HOLD_CYC,
  parameter int unsigned STEP_CYC = mrc_pkg::CFG_STEP_CYC,
  parameter int unsigned N_IFACE = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ext_rst_n_in,
  input wire logic sw_rst_req_in,
  input wire logic save_done_in,
  input wire logic detach_done_in,
  output mrc_pkg::mrc_dom_t dom_out,
  output mrc_pkg::mrc_shut_t shut_out,
  output logic [N_IFACE-1:0] iface_cfg_out,
  output logic ready_out,
  output logic poweron_start_out
);
  import mrc_pkg::*;

  // Every check below runs in this one clock domain
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  localparam int unsigned TW = 24;

  initial begin
    if (HOLD_CYC < 1 || HOLD_CYC >= (1 << TW))
      $error("HOLD_CYC out of range");
    if (REGUP_CYC < 1 || BBHOLD_CYC < 1 || STEP_CYC < 1)
      $error("Sequence counts must be nonzero");
    if (N_IFACE < 1 || N_IFACE > 16)
      $error("N_IFACE out of range");
  end

  // ****************************************
  // Pin sampling
  // ****************************************
  logic rst_n_s;
  logic rst_n_prev_q;
  logic release_pulse;

  mrc_sync u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(ext_rst_n_in),
    .sync_out(rst_n_s)
  );

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) rst_n_prev_q <= 1'b1;
    else rst_n_prev_q <= rst_n_s;
  end

  // ****************************************
  // Low-time qualification
  // ****************************************
  logic low_done;
  logic hw_armed_q;

  mrc_timer #(.WIDTH(TW)) u_low (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(rst_n_s),
    .limit_in(TW'(HOLD_CYC - 1)),
    .done_out(low_done)
  );

  // Short glitches never reach the reset path
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) hw_armed_q <= 1'b0;
    else if (rst_n_s) hw_armed_q <= 1'b0;
    else if (low_done) hw_armed_q <= 1'b1; // RULE2
  end

  // One start per qualified release only
  assign release_pulse = rst_n_s && !rst_n_prev_q && hw_armed_q; // RULE15

  // ****************************************
  // Sequencer
  // ****************************************
  mrc_state_t state_q;
  logic [TW-1:0] seq_cnt_q;
  logic [4:0] step_q;
  logic sw_pend_q;
  logic save_ok_q;
  logic det_ok_q;

  // Pending command, set wins over clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) sw_pend_q <= 1'b0;
    else if (sw_rst_req_in) sw_pend_q <= 1'b1;
    else if (state_q == MRC_SW_SAVE || state_q == MRC_HW_RST)
      sw_pend_q <= 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || state_q != MRC_SW_SAVE) begin
      save_ok_q <= 1'b0;
      det_ok_q <= 1'b0;
    end else begin
      if (save_done_in) save_ok_q <= 1'b1;
      if (detach_done_in) det_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q <= MRC_REG_UP;
      seq_cnt_q <= '0;
      step_q <= '0;
    end else if (hw_armed_q && !rst_n_s) begin
      // Pin path overrides everything, even a save in progress
      state_q <= MRC_HW_RST; // RULE1 RULE3
      seq_cnt_q <= '0;
      step_q <= '0;
    end else begin
      case (state_q)
        MRC_RUN: begin
          if (sw_pend_q) state_q <= MRC_SW_SAVE; // RULE1
        end
        MRC_HW_RST: begin
          if (release_pulse) state_q <= MRC_REG_UP; // RULE9
        end
        MRC_SW_SAVE: begin
          if (save_ok_q && det_ok_q) begin
            state_q <= MRC_BB_HOLD; // RULE10
            seq_cnt_q <= '0;
          end
        end
        MRC_REG_UP: begin
          if (seq_cnt_q == TW'(REGUP_CYC - 1)) begin
            state_q <= MRC_BB_HOLD; // RULE14
            seq_cnt_q <= '0;
          end else seq_cnt_q <= seq_cnt_q + 1'b1;
        end
        MRC_BB_HOLD: begin
          if (seq_cnt_q == TW'(BBHOLD_CYC - 1)) begin
            state_q <= MRC_CONFIG; // RULE14
            seq_cnt_q <= '0;
            step_q <= '0;
          end else seq_cnt_q <= seq_cnt_q + 1'b1;
        end
        MRC_CONFIG: begin
          if (seq_cnt_q == TW'(STEP_CYC - 1)) begin
            seq_cnt_q <= '0;
            if (step_q == 5'(N_IFACE - 1)) state_q <= MRC_RUN;
            else step_q <= step_q + 1'b1;
          end else seq_cnt_q <= seq_cnt_q + 1'b1;
        end
        default: state_q <= MRC_HW_RST;
      endcase
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dom_out <= '{iface_rail_en: 1'b0, backup_rail_en: 1'b1,
                   pmu_rst: 1'b0, bb_rst: 1'b1, pins_tristate: 1'b1,
                   pins_reset_state: 1'b0};
    end else begin
      dom_out.backup_rail_en <= 1'b1; // RULE4 RULE7
      dom_out.pmu_rst <= (state_q == MRC_HW_RST); // RULE3 RULE6
      dom_out.bb_rst <= (state_q != MRC_RUN && state_q != MRC_CONFIG);
      dom_out.iface_rail_en <= !(state_q == MRC_HW_RST ||
                                 state_q == MRC_REG_UP); // RULE4 RULE7
      dom_out.pins_tristate <= (state_q == MRC_HW_RST ||
                                state_q == MRC_REG_UP); // RULE4 RULE14
      dom_out.pins_reset_state <= (state_q == MRC_SW_SAVE ||
                                   state_q == MRC_BB_HOLD); // RULE7
    end
  end

  // Save and detach only requested on the command path
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) shut_out <= '0;
    else begin
      shut_out.save_req <= (state_q == MRC_SW_SAVE) &&
        !save_ok_q; // RULE8 RULE5
      shut_out.detach_req <= (state_q == MRC_SW_SAVE) &&
        !det_ok_q; // RULE8 RULE5
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IFACE; gi++) begin : g_cfg
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) iface_cfg_out[gi] <= 1'b0;
        else iface_cfg_out[gi] <= (state_q == MRC_RUN) ||
          (state_q == MRC_CONFIG && step_q > 5'(gi)); // RULE14
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ready_out <= 1'b0;
      poweron_start_out <= 1'b0;
    end else begin
      ready_out <= (state_q == MRC_RUN);
      poweron_start_out <= release_pulse ||
        (state_q == MRC_SW_SAVE && save_ok_q && det_ok_q); // RULE9 RULE10
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_armed_low;
    hw_armed_q && !rst_n_s;
  endsequence

  sequence s_release;
    s_armed_low ##1 rst_n_s;
  endsequence

  sequence s_in_hw;
    state_q == MRC_HW_RST;
  endsequence

  sequence s_in_save;
    state_q == MRC_SW_SAVE;
  endsequence

  // Both answers in, pin not pulling the other way
  sequence s_save_both;
    state_q == MRC_SW_SAVE && save_ok_q && det_ok_q && rst_n_s;
  endsequence

  sequence s_in_boot;
    state_q == MRC_REG_UP;
  endsequence

  // Pin path
  a_release_start: assert property (s_release |=> poweron_start_out) // RULE9
    else $error("Release did not start power-on");
  a_one_start: assert property (release_pulse |=> !release_pulse) // RULE15
    else $error("Power-on started twice");
  a_held_no_start: assert property (s_in_hw ##0 !rst_n_s |=> // RULE15
    !poweron_start_out)
    else $error("Power-on started while pin held");
  a_short_low: assert property ( // RULE2
    !rst_n_s && !low_done && !hw_armed_q |=> !hw_armed_q)
    else $error("Armed before hold time");

  // Hardware reset domains
  a_hw_pins_off: assert property (s_in_hw |=> // RULE4
    dom_out.pins_tristate && !dom_out.iface_rail_en)
    else $error("Pins or rail active in hardware reset");
  a_hw_no_save: assert property (s_in_hw |=> // RULE5
    !shut_out.save_req && !shut_out.detach_req)
    else $error("Save requested in hardware reset");
  a_hw_pmu: assert property (s_in_hw |=> // RULE3
    dom_out.pmu_rst && dom_out.bb_rst && dom_out.backup_rail_en)
    else $error("Domains not reset in hardware reset");
  a_pmu_only_hw: assert property (state_q != MRC_HW_RST |=> // RULE6
    !dom_out.pmu_rst)
    else $error("PMU reset outside hardware reset");

  // Command path
  a_cmd_latched: assert property (sw_rst_req_in |=> sw_pend_q) // RULE1
    else $error("Command request lost");
  a_cmd_acted: assert property ( // RULE1
    sw_pend_q && state_q == MRC_RUN && rst_n_s |=> s_in_save)
    else $error("Pending command not acted upon");
  a_sw_domains: assert property (s_in_save |=> // RULE6 RULE7
    dom_out.bb_rst && !dom_out.pmu_rst &&
      dom_out.iface_rail_en && dom_out.pins_reset_state)
    else $error("Wrong domains in software reset");
  a_sw_pins_driven: assert property (s_in_save |=> // RULE7
    !dom_out.pins_tristate && dom_out.backup_rail_en)
    else $error("Pins floated in software reset");
  a_sw_save_req: assert property ($rose(state_q == MRC_SW_SAVE) |=> // RULE8
    shut_out.save_req && shut_out.detach_req)
    else $error("Save or detach not requested");
  a_sw_wait: assert property ( // RULE10
    s_in_save ##0 !(save_ok_q && det_ok_q) && rst_n_s |=> s_in_save)
    else $error("Left save before completion");
  a_sw_start: assert property (s_save_both |=> // RULE10
    poweron_start_out && state_q == MRC_BB_HOLD)
    else $error("Software path did not start power-on");

  // Power-on sequence
  a_boot_tristate: assert property (s_in_boot |=> // RULE14
    dom_out.pins_tristate && dom_out.bb_rst && !dom_out.iface_rail_en)
    else $error("Pins driven before regulators up");
  a_hold_unconfig: assert property (state_q == MRC_BB_HOLD |=> // RULE14
    dom_out.bb_rst && iface_cfg_out == '0)
    else $error("Interface configured while baseband held");
  a_cfg_order: assert property ($rose(state_q == MRC_CONFIG) |=> // RULE14
    iface_cfg_out == '0)
    else $error("Interface configured out of order");
  a_ready_cfg: assert property (ready_out |-> // RULE14
    &iface_cfg_out && !dom_out.bb_rst && dom_out.iface_rail_en)
    else $error("Ready before every interface configured");
endmodule
`default_nettype wire

// ---- hdl/mrc_pkg.sv ----
// Contract
// RULE1: Two reset paths: pin and command.
// RULE2: Pin low 50 ms triggers hardware reset.
// RULE3: Hardware reset hits all but clock block.
// RULE4: Hardware reset: rail off, pins tri-stated.
// RULE5: Hardware reset skips save and detach.
// RULE6: Software reset hits baseband only.
// RULE7: Software reset: rail on, pins reset state.
// RULE8: Software reset saves settings and detaches.
// RULE9: Pin release starts power-on sequence.
// RULE10: Software power-on waits for save, detach.
// RULE11: Host tri-states during reset and boot.
// RULE12: Host keeps reset pin level defined.
// RULE13: Open-drain host drive; internal pull-up idles. Host model drives the pin high itself.
// RULE14: Tri-state until regulators, hold, configure.
// RULE15: Synchronise release; one sequence per release.
`default_nettype none
package mrc_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned HW_HOLD_MS = 50;
  localparam longint unsigned HW_HOLD_CYC_L =
    (longint'(HW_HOLD_MS) * CLK_HZ + 999) / 1000;
  localparam int unsigned HW_HOLD_CYC = int'(HW_HOLD_CYC_L);
  localparam int unsigned REG_UP_CYC = 1000;
  localparam int unsigned BB_HOLD_CYC = 1000;
  localparam int unsigned CFG_STEP_CYC = 16;

  typedef enum logic [2:0] {
    MRC_RUN = 3'h0,
    MRC_HW_RST = 3'h1,
    MRC_SW_SAVE = 3'h2,
    MRC_REG_UP = 3'h3,
    MRC_BB_HOLD = 3'h4,
    MRC_CONFIG = 3'h5
  } mrc_state_t;

  typedef struct packed {
    logic iface_rail_en;
    logic backup_rail_en;
    logic pmu_rst;
    logic bb_rst;
    logic pins_tristate;
    logic pins_reset_state;
  } mrc_dom_t;

  typedef struct packed {
    logic save_req;
    logic detach_req;
  } mrc_shut_t;
endpackage
`default_nettype wire

// ---- hdl/mrc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrc_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  // Reset to high: pull-up idle level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_q <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/mrc_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrc_timer #(
  parameter int unsigned WIDTH = 24
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] limit_in,
  output logic done_out
);
  logic [WIDTH-1:0] cnt_q;
  initial begin
    if (WIDTH < 2) $error("mrc_timer width too small");
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || clear_in) begin
      cnt_q <= '0;
    end else if (cnt_q != limit_in) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign done_out = (cnt_q == limit_in) && !clear_in;
endmodule
`default_nettype wire

// ---- verification/mrc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side: reset pin driver and modem
// firmware answering save and detach
// ****************************************
module mrc_host_model (
  input wire logic clk_in,
  input wire logic hold_low_in,
  input wire logic [7:0] save_dly_in,
  input wire logic [7:0] detach_dly_in,
  input wire logic save_req_in,
  input wire logic detach_req_in,
  input wire logic mod_ready_in,
  output logic ext_rst_n_out,
  output logic save_done_out,
  output logic detach_done_out,
  output logic host_oe_out
);
  logic [7:0] save_cnt_q = 8'h00;
  logic [7:0] det_cnt_q = 8'h00;

  // Driven low while held, driven high when released, so the level is always defined
  assign ext_rst_n_out = hold_low_in ? 1'b0 : 1'b1;

  // Host lines stay floating while reset is held and until ready
  assign host_oe_out = mod_ready_in && !hold_low_in;

  // One done pulse per request, after a programmable delay
  always @(negedge clk_in) begin
    if (!save_req_in) begin
      save_cnt_q <= 8'h00;
    end else if (save_cnt_q != 8'hFF) begin
      save_cnt_q <= save_cnt_q + 8'h01;
    end
    if (!detach_req_in) begin
      det_cnt_q <= 8'h00;
    end else if (det_cnt_q != 8'hFF) begin
      det_cnt_q <= det_cnt_q + 8'h01;
    end
    save_done_out <= save_req_in && (save_cnt_q == save_dly_in);
    detach_done_out <= detach_req_in && (det_cnt_q == detach_dly_in);
  end
endmodule
`default_nettype wire

// ---- verification/tb_module_reset_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_module_reset_control;
  import mrc_pkg::*;
  localparam int HOLD = 20;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sw_rst_req_in = 1'b0;
  logic hold_low = 1'b0;
  logic [7:0] save_dly = 8'h02;
  logic [7:0] det_dly = 8'h02;
  wire logic ext_rst_n;
  wire logic save_done;
  wire logic detach_done;
  wire logic host_oe;
  mrc_dom_t dom;
  mrc_shut_t shut;
  logic [3:0] cfg;
  logic ready;
  logic po;
  int err_total = 0;
  int n_checks = 0;
  int n_po = 0;
  int cyc = 0;
  int n0;
  int i;

  always #2.5 clk_in = ~clk_in;

  mrc_module_reset_control #(.HOLD_CYC(HOLD), .REGUP_CYC(8),
    .BBHOLD_CYC(8), .STEP_CYC(4), .N_IFACE(4)) DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ext_rst_n_in(ext_rst_n),
    .sw_rst_req_in(sw_rst_req_in), .save_done_in(save_done),
    .detach_done_in(detach_done), .dom_out(dom), .shut_out(shut),
    .iface_cfg_out(cfg), .ready_out(ready), .poweron_start_out(po));

  mrc_host_model host (
    .clk_in(clk_in), .hold_low_in(hold_low), .save_dly_in(save_dly),
    .detach_dly_in(det_dly), .save_req_in(shut.save_req),
    .detach_req_in(shut.detach_req), .mod_ready_in(ready),
    .ext_rst_n_out(ext_rst_n), .save_done_out(save_done),
    .detach_done_out(detach_done), .host_oe_out(host_oe));

  // ****************************************
  // Monitors and checking helpers
  // ****************************************
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (po === 1'b1) begin
      n_po <= n_po + 1;
    end
    // Whole run needs about 500 cycles
    if (cyc == 6000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic ck(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_ready();
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(negedge clk_in);
  endtask

  task automatic sw_pulse();
    sw_rst_req_in = 1'b1;
    @(negedge clk_in);
    sw_rst_req_in = 1'b0;
    for (i = 0; i < 20 && shut.save_req !== 1'b1; i++) @(negedge clk_in);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_boot();
    ck("dom in reset", 32'(dom), 32'h16);
    sys_rst_in = 1'b0;
    wait_ready();
    ck("ready", 32'(ready), 32'h1);
    ck("dom running", 32'(dom), 32'h30);
    ck("iface cfg", 32'(cfg), 32'hF);
    ck("host oe run", 32'(host_oe), 32'h1);
    $display("test boot done");
  endtask

  task automatic t_short_low();
    n0 = n_po;
    hold_low = 1'b1;
    repeat (HOLD - 4) @(negedge clk_in);
    hold_low = 1'b0;
    repeat (10) @(negedge clk_in);
    ck("ready short", 32'(ready), 32'h1);
    ck("pmu short", 32'(dom.pmu_rst), 32'h0);
    ck("starts short", 32'(n_po - n0), 32'h0);
    $display("test short low done");
  endtask

  task automatic t_hw_over_save();
    // Slow firmware, pin reset lands in the middle of the save
    save_dly = 8'hF0;
    det_dly = 8'hF0;
    sw_pulse();
    hold_low = 1'b1;
    repeat (HOLD + 6) @(negedge clk_in);
    ck("pmu hw", 32'(dom.pmu_rst), 32'h1);
    ck("bb hw", 32'(dom.bb_rst), 32'h1);
    ck("rail hw", 32'(dom.iface_rail_en), 32'h0);
    ck("tristate hw", 32'(dom.pins_tristate), 32'h1);
    ck("backup hw", 32'(dom.backup_rail_en), 32'h1);
    ck("shut hw", 32'(shut), 32'h0);
    ck("host oe hw", 32'(host_oe), 32'h0);
    n0 = n_po;
    hold_low = 1'b0;
    wait_ready();
    ck("ready hw", 32'(ready), 32'h1);
    ck("starts hw", 32'(n_po - n0), 32'h1);
    save_dly = 8'h02;
    $display("test hardware reset done");
  endtask

  task automatic t_sw();
    det_dly = 8'h28;
    repeat (300) @(negedge clk_in);
    wait_ready();
    n0 = n_po;
    sw_pulse();
    ck("shut sw", 32'(shut), 32'h3);
    ck("rail sw", 32'(dom.iface_rail_en), 32'h1);
    ck("reset state sw", 32'(dom.pins_reset_state), 32'h1);
    ck("backup sw", 32'(dom.backup_rail_en), 32'h1);
    ck("pmu sw", 32'(dom.pmu_rst), 32'h0);
    ck("bb sw", 32'(dom.bb_rst), 32'h1);
    repeat (20) @(negedge clk_in);
    ck("save dropped", 32'(shut.save_req), 32'h0);
    ck("early start", 32'(n_po - n0), 32'h0);
    wait_ready();
    ck("ready sw", 32'(ready), 32'h1);
    ck("starts sw", 32'(n_po - n0), 32'h1);
    $display("test software reset done");
  endtask

  initial begin
    repeat (3) @(negedge clk_in);
    t_boot();
    t_short_low();
    t_hw_over_save();
    t_sw();
    end_sim();
  end
endmodule
`default_nettype wire
